// [hw/port1_pkg.sv]
`default_nettype none

package port1_pkg;

    // Port geometry and bus widths
    localparam int PORT_WIDTH = 8;
    localparam int ADDR_WIDTH = 16;
    localparam int DATA_WIDTH = 32;

    // Register byte addresses (all printed offsets are word aligned)
    localparam logic [15:0] OFF_PIN_FUNCTION_SELECT = 16'hff98;
    localparam logic [15:0] OFF_PULLUP_CONTROL      = 16'hff9c;
    localparam logic [15:0] OFF_OUTPUT_LATCH        = 16'hffd4;
    localparam logic [15:0] OFF_DIRECTION           = 16'hffe4;

    // Values after reset
    localparam logic [7:0] RST_PIN_FUNCTION_SELECT = 8'h00;
    localparam logic [7:0] RST_PULLUP_CONTROL      = 8'h00;
    localparam logic [7:0] RST_OUTPUT_LATCH        = 8'h00;
    localparam logic [7:0] RST_DIRECTION           = 8'h00;
    localparam logic [7:0] RST_PIN_OE_N            = 8'hff;
    localparam logic [7:0] RST_PIN_OUT             = 8'h00;
    localparam logic [7:0] RST_PULLUP_EN           = 8'h00;
    localparam logic       RST_EXT_INTERRUPT       = 1'b1;

    // Read value of the write-only direction register
    localparam logic [7:0] DIRECTION_READ_VALUE = 8'hff;

    // Pin function select field positions
    localparam int BIT_EXT_INTERRUPT_THREE = 7;
    localparam int BIT_EXT_INTERRUPT_TWO   = 6;
    localparam int BIT_EXT_INTERRUPT_ONE   = 5;
    localparam int BIT_RESERVED            = 4;
    localparam int BIT_CAPTURE_INPUT       = 3;
    localparam int BIT_COMPARE_OUT_HIGH    = 2;
    localparam int BIT_COMPARE_OUT_LOW     = 1;
    localparam int BIT_CLOCK_OUT           = 0;

    // Field groups of the pin function select register
    localparam logic [7:0] MODE_WRITABLE_MASK = 8'hef;
    localparam logic [7:0] MODE_ALT_IN_MASK   = 8'he8;
    localparam logic [7:0] MODE_ALT_OUT_MASK  = 8'h07;

    // Timer clock select value that routes pin 7 to the event input
    localparam logic [2:0] EVENT_SEL_PIN = 3'h0;

endpackage

`default_nettype wire

// [hw/pin_sync_if.sv]
`default_nettype none

// Synchronised pin levels handed from the synchroniser to the port
interface pin_sync_if
    import port1_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
);
    logic [WIDTH-1:0] level;

    modport producer (output level);
    modport consumer (input level);
endinterface

`default_nettype wire

// [hw/pin_synchroniser.sv]
`default_nettype none

module pin_synchroniser
    import port1_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin_raw,
    pin_sync_if.producer          sync
);

    logic [WIDTH-1:0] stage_one;

    // First stage feeds only the second; pins are asynchronous
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_one  <= '0;
            sync.level <= '0;
        end else begin
            stage_one  <= pin_raw;
            sync.level <= stage_one;
        end
    end

endmodule

`default_nettype wire

// [hw/port1_gpio_block.sv]
// Overview of operation
// RULE_01 - Eight-bit output latch holds one data bit per port pin.
// RULE_02 - Each pin's direction is chosen independently of the others.
// RULE_03 - Port read returns latch bit where direction bit is one.
// RULE_04 - Port read returns sampled pin level where direction bit is zero.
// RULE_05 - Reset clears the output latch to zero.
// RULE_06 - Direction bit one makes the pin an output driven by its latch.
// RULE_07 - Direction bit zero makes the pin an input, driver off.
// RULE_08 - Direction and latch act only while the pin is general I/O; the direction bit still gates the pull-up on alternate input pins.
// RULE_09 - Direction register is write-only and reads as all ones.
// RULE_10 - Reset clears the direction register, all pins inputs.
// RULE_11 - Pins 7 to 5 may serve as external interrupt inputs 3 to 1.
// RULE_12 - Pin 7 may feed the timer event input, gated by clock select.
// RULE_13 - Pin 3 may serve as the capture timer input.
// RULE_14 - Pins 2 and 1 may drive compare high and low outputs.
// RULE_15 - Pin 0 may drive the interval timer clock output.
// RULE_16 - For input pins, pull-up bit one enables the pull-up, zero not.
// RULE_17 - Mode bit one selects alternate function, zero general I/O.
// RULE_18 - Mode bit 4 is reserved and always reads as zero.
// RULE_19 - Selected peripheral output drives the pin regardless of latch.
`default_nettype none

module port1_gpio_block
    import port1_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [DATA_WIDTH-1:0] pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [DATA_WIDTH-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [PORT_WIDTH-1:0] pin_in,
    output logic      [PORT_WIDTH-1:0] pin_out,
    output logic      [PORT_WIDTH-1:0] pin_oe_n,
    output logic      [PORT_WIDTH-1:0] pullup_en,
    input  wire logic                  compare_out_high,
    input  wire logic                  compare_out_low,
    input  wire logic                  interval_timer_clock_out,
    input  wire logic [2:0]            event_clock_select,
    output logic                       ext_interrupt_three,
    output logic                       ext_interrupt_two,
    output logic                       ext_interrupt_one,
    output logic                       timer_event_input,
    output logic                       capture_timer_input
);

    // Software-visible registers
    logic [7:0] port1_output_latch;
    logic [7:0] port1_direction;
    logic [7:0] port1_pullup_control;
    logic [7:0] port1_pin_function_select;

    // Next values of the pin-side flops
    logic [7:0] next_pin_out;
    logic [7:0] next_pin_oe_n;
    logic [7:0] next_pullup_en;
    logic [7:0] alt_out;

    // Bus phase decode
    logic       setup_phase;
    logic       access_phase;
    logic       wr_commit;
    logic [7:0] wr_byte;

    pin_sync_if #(.WIDTH(PORT_WIDTH)) sync_bus ();

    // Pins come from the board, so two flops before any use
    pin_synchroniser #(
        .WIDTH (PORT_WIDTH)
    ) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_raw (pin_in),
        .sync    (sync_bus.producer)
    );

    // Address compare, used for every register
    function automatic logic reg_hit(input logic [15:0] addr,
                                     input logic [15:0] off);
        return addr == off;
    endfunction

    // Any documented register at this address
    function automatic logic mapped(input logic [15:0] addr);
        return reg_hit(addr, OFF_PIN_FUNCTION_SELECT)
            || reg_hit(addr, OFF_PULLUP_CONTROL)
            || reg_hit(addr, OFF_OUTPUT_LATCH)
            || reg_hit(addr, OFF_DIRECTION);
    endfunction

    // Port data read: latch for outputs, pin level for inputs
    function automatic logic [7:0] port_read(input logic [7:0] latch,
                                             input logic [7:0] dir,
                                             input logic [7:0] pins);
        return (latch & dir) | (pins & ~dir);
    endfunction

    // Read mux; upper bits read as zero
    function automatic logic [31:0] read_word(input logic [15:0] addr,
                                              input logic [7:0] latch,
                                              input logic [7:0] dir,
                                              input logic [7:0] pucr,
                                              input logic [7:0] mode,
                                              input logic [7:0] pins);
        logic [7:0] value;
        value = 8'h00;
        if (reg_hit(addr, OFF_OUTPUT_LATCH)) begin
            value = port_read(latch, dir, pins);       // see RULE_03
        end else if (reg_hit(addr, OFF_DIRECTION)) begin
            value = DIRECTION_READ_VALUE;              // see RULE_09
        end else if (reg_hit(addr, OFF_PULLUP_CONTROL)) begin
            value = pucr;
        end else if (reg_hit(addr, OFF_PIN_FUNCTION_SELECT)) begin
            value = mode & MODE_WRITABLE_MASK;         // see RULE_18
        end
        return {24'h000000, value};
    endfunction

    // Setup and access phases of the APB transfer
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable && pready;
    assign wr_commit    = access_phase && pwrite && pstrb[0];
    assign wr_byte      = pwdata[7:0];

    // Zero-wait answer: pready is high in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_phase && !pready) begin
            pready  <= 1'b1;
            pslverr <= !mapped(paddr);
            if (pwrite) begin
                prdata <= 32'h00000000;
            end else begin
                prdata <= read_word(paddr, port1_output_latch,
                                    port1_direction, port1_pullup_control,
                                    port1_pin_function_select,
                                    sync_bus.level);   // see RULE_04
            end
        end else begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

    // Output latch, one bit per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port1_output_latch <= RST_OUTPUT_LATCH;     // see RULE_05
        end else if (wr_commit && reg_hit(paddr, OFF_OUTPUT_LATCH)) begin
            port1_output_latch <= wr_byte;              // see RULE_01
        end
    end

    // Direction bits, each written independently of the others
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port1_direction <= RST_DIRECTION;           // see RULE_10
        end else if (wr_commit && reg_hit(paddr, OFF_DIRECTION)) begin
            port1_direction <= wr_byte;                 // see RULE_02
        end
    end

    // Pull-up enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port1_pullup_control <= RST_PULLUP_CONTROL;
        end else if (wr_commit && reg_hit(paddr, OFF_PULLUP_CONTROL)) begin
            port1_pullup_control <= wr_byte;
        end
    end

    // Pin function select; reserved bit never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port1_pin_function_select <= RST_PIN_FUNCTION_SELECT;
        end else if (wr_commit
                     && reg_hit(paddr, OFF_PIN_FUNCTION_SELECT)) begin
            port1_pin_function_select <= wr_byte
                                         & MODE_WRITABLE_MASK; // see RULE_17
        end
    end

    // Pin drive: general I/O, alternate input, or peripheral output
    always_comb begin
        alt_out = 8'h00;
        alt_out[BIT_COMPARE_OUT_HIGH] = compare_out_high;     // see RULE_14
        alt_out[BIT_COMPARE_OUT_LOW]  = compare_out_low;      // see RULE_14
        alt_out[BIT_CLOCK_OUT] = interval_timer_clock_out; // see RULE_15
        // Latch and direction only count for general I/O pins
        next_pin_out = (port1_output_latch & ~port1_pin_function_select)
                     | (alt_out & port1_pin_function_select
                        & MODE_ALT_OUT_MASK);                 // see RULE_19
        next_pin_oe_n = (~port1_direction & ~port1_pin_function_select)
                      | (port1_pin_function_select
                         & MODE_ALT_IN_MASK);                 // see RULE_08
        // Pull-up off where a peripheral drives the pin
        next_pullup_en = port1_pullup_control & ~port1_direction
                       & ~(port1_pin_function_select
                           & MODE_ALT_OUT_MASK);              // see RULE_16
    end

    // Pin flops, so the pads see no decode glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out   <= RST_PIN_OUT;
            pin_oe_n  <= RST_PIN_OE_N;
            pullup_en <= RST_PULLUP_EN;
        end else begin
            pin_out   <= next_pin_out;                  // see RULE_06
            pin_oe_n  <= next_pin_oe_n;                 // see RULE_07
            pullup_en <= next_pullup_en;
        end
    end

    // Alternate inputs; deselected lines rest at their idle level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_interrupt_three <= RST_EXT_INTERRUPT;
            ext_interrupt_two   <= RST_EXT_INTERRUPT;
            ext_interrupt_one   <= RST_EXT_INTERRUPT;
            timer_event_input   <= 1'b0;
            capture_timer_input <= 1'b0;
        end else begin
            ext_interrupt_three <=
                port1_pin_function_select[BIT_EXT_INTERRUPT_THREE]
                ? sync_bus.level[BIT_EXT_INTERRUPT_THREE]
                : RST_EXT_INTERRUPT;                    // see RULE_11
            ext_interrupt_two <=
                port1_pin_function_select[BIT_EXT_INTERRUPT_TWO]
                ? sync_bus.level[BIT_EXT_INTERRUPT_TWO]
                : RST_EXT_INTERRUPT;                    // see RULE_11
            ext_interrupt_one <=
                port1_pin_function_select[BIT_EXT_INTERRUPT_ONE]
                ? sync_bus.level[BIT_EXT_INTERRUPT_ONE]
                : RST_EXT_INTERRUPT;                    // see RULE_11
            // Event input shares pin 7 only when the timer asks for it
            timer_event_input <=
                port1_pin_function_select[BIT_EXT_INTERRUPT_THREE]
                && (event_clock_select == EVENT_SEL_PIN)
                && sync_bus.level[BIT_EXT_INTERRUPT_THREE]; // see RULE_12
            capture_timer_input <=
                port1_pin_function_select[BIT_CAPTURE_INPUT]
                && sync_bus.level[BIT_CAPTURE_INPUT];   // see RULE_13
        end
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic read_answer;
    assign read_answer = access_phase && !pwrite;

    property p_latch_write;
        wr_commit && reg_hit(paddr, OFF_OUTPUT_LATCH)
            |=> port1_output_latch == $past(wr_byte);
    endproperty
    a_latch_write: assert property (p_latch_write) // see RULE_01
        else $error("latch did not take written byte");

    property p_dir_write;
        wr_commit && reg_hit(paddr, OFF_DIRECTION)
            |=> port1_direction == $past(wr_byte);
    endproperty
    a_dir_write: assert property (p_dir_write) // see RULE_02
        else $error("direction did not take written byte");

    property p_read_outputs;
        read_answer && reg_hit(paddr, OFF_OUTPUT_LATCH)
            |-> ((prdata[7:0] ^ port1_output_latch)
                 & port1_direction) == 8'h00;
    endproperty
    a_read_outputs: assert property (p_read_outputs) // see RULE_03
        else $error("output pin read did not return latch");

    property p_read_inputs;
        read_answer && reg_hit(paddr, OFF_OUTPUT_LATCH)
            |-> ((prdata[7:0] ^ $past(sync_bus.level))
                 & ~port1_direction) == 8'h00;
    endproperty
    a_read_inputs: assert property (p_read_inputs) // see RULE_04
        else $error("input pin read did not return pin level");

    property p_reset_values;
        $rose(presetn) |-> port1_output_latch == RST_OUTPUT_LATCH
                        && port1_direction == RST_DIRECTION;
    endproperty
    a_reset_values: assert property (p_reset_values) // see RULE_05
        else $error("latch or direction not cleared by reset");

    property p_gpio_drive;
        1'b1 |=> (((pin_oe_n ^ ~$past(port1_direction))
                   | (pin_out ^ $past(port1_output_latch)))
                  & ~$past(port1_pin_function_select)) == 8'h00;
    endproperty
    a_gpio_drive: assert property (p_gpio_drive) // see RULE_08
        else $error("general pin drive does not follow registers");

    property p_dir_reads_ones;
        read_answer && reg_hit(paddr, OFF_DIRECTION)
            |-> prdata == 32'h000000ff;
    endproperty
    a_dir_reads_ones: assert property (p_dir_reads_ones) // see RULE_09
        else $error("direction read not all ones");

    property p_ext_interrupt;
        port1_pin_function_select[BIT_EXT_INTERRUPT_THREE]
            |=> ext_interrupt_three
                == $past(sync_bus.level[BIT_EXT_INTERRUPT_THREE])
                && pin_oe_n[BIT_EXT_INTERRUPT_THREE];
    endproperty
    a_ext_interrupt: assert property (p_ext_interrupt) // see RULE_11
        else $error("interrupt three does not follow pin 7");

    property p_event_gate;
        event_clock_select != EVENT_SEL_PIN |=> !timer_event_input;
    endproperty
    a_event_gate: assert property (p_event_gate) // see RULE_12
        else $error("event input active with other clock select");

    property p_compare_drive;
        port1_pin_function_select[BIT_COMPARE_OUT_HIGH]
            |=> pin_out[BIT_COMPARE_OUT_HIGH] == $past(compare_out_high)
                && !pin_oe_n[BIT_COMPARE_OUT_HIGH];
    endproperty
    a_compare_drive: assert property (p_compare_drive) // see RULE_14
        else $error("compare high not driven on pin 2");

    property p_pullup;
        1'b1 |=> pullup_en[5] == ($past(port1_pullup_control[5])
                                  && !$past(port1_direction[5]));
    endproperty
    a_pullup: assert property (p_pullup) // see RULE_16
        else $error("pull-up on pin 5 wrong");

    property p_reserved_zero;
        read_answer && reg_hit(paddr, OFF_PIN_FUNCTION_SELECT)
            |-> !prdata[BIT_RESERVED];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // see RULE_18
        else $error("reserved mode bit read as one");

    // Main scenarios
    c_pin_read: cover property (
        read_answer && reg_hit(paddr, OFF_OUTPUT_LATCH));
    c_output_pin: cover property (
        port1_direction[0] && !port1_pin_function_select[0]
        ##1 !pin_oe_n[0]);
    c_compare_low: cover property (
        port1_pin_function_select[BIT_COMPARE_OUT_LOW] && compare_out_low
        ##1 pin_out[BIT_COMPARE_OUT_LOW]);

endmodule

`default_nettype wire

// [verif/port1_board_model.sv]
`default_nettype none

// Board side of the eight port pins: external drivers, pull-ups, float
module port1_board_model
    import port1_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic [PORT_WIDTH-1:0] pin_out,
    input  wire logic [PORT_WIDTH-1:0] pin_oe_n,
    input  wire logic [PORT_WIDTH-1:0] pullup_en,
    input  wire logic [PORT_WIDTH-1:0] drive_en,
    input  wire logic [PORT_WIDTH-1:0] drive_val,
    output logic      [PORT_WIDTH-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [PORT_WIDTH-1:0] float_pat = 8'h55;

    // An undriven pin wanders; never trust it to hold its last level
    always @(posedge pclk) begin
        float_pat <= ~float_pat;
    end

    // Block driver wins, then the board, then the pull-up, else float
    always_comb begin
        for (int i = 0; i < PORT_WIDTH; i++) begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (drive_en[i])
                pin_in[i] = drive_val[i];
            else if (pullup_en[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = float_pat[i];
        end
    end
endmodule

`default_nettype wire

// [verif/port1_gpio_block_tb_top.sv]
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    bad_count++; \
    $display("wrong value at %0t got %h exp %h", $time, g, e); end end

module port1_gpio_block_tb_top
    import port1_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        pready, pslverr;
    logic [7:0]  pin_in, pin_out, pin_oe_n, pullup_en, drv_en, drv_val;
    logic        cmp_hi, cmp_lo, itv_clk, ei3, ei2, ei1, ev_in, cap_in;
    logic [2:0]  ev_sel, per;
    logic [31:0] rdv;
    logic        err;
    logic [7:0]  latch, dir, pucr, mode, lo;
    int          seed = 32'h605e218b;
    int          bad_count = 0;
    int          num_checks = 0;

    // 10 MHz bus clock
    always #50 pclk = ~pclk;

    port1_gpio_block DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .compare_out_high(cmp_hi),
        .compare_out_low(cmp_lo), .interval_timer_clock_out(itv_clk),
        .event_clock_select(ev_sel), .ext_interrupt_three(ei3),
        .ext_interrupt_two(ei2), .ext_interrupt_one(ei1),
        .timer_event_input(ev_in), .capture_timer_input(cap_in));

    port1_board_model board (.pclk(pclk), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .drive_en(drv_en),
        .drive_val(drv_val), .pin_in(pin_in));

    // Port read: latch where output, pin level where input
    function automatic logic [31:0] exp_port(logic [7:0] l, logic [7:0] d,
                                             logic [7:0] p);
        return {24'h0, (l & d) | (p & ~d)};
    endfunction

    // Low three pins: peripheral output when selected, else the latch
    function automatic logic [7:0] exp_low(logic [7:0] m, logic [7:0] l,
                                           logic [2:0] per);
        return {5'h0, (m[2:0] & per) | (~m[2:0] & l[2:0])};
    endfunction

    // One APB transfer; entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // No wait limit here; a hang is caught by the watchdog
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 4'hf);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        `CHK({err, rdv}, {1'b0, e})
    endtask

    // Registered outputs and the two-flop pin path need four edges
    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog, well beyond the roughly 900 cycles the run needs
    initial begin
        #3000000;
        bad_count++;
        end_sim();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {drv_en, drv_val, cmp_hi, cmp_lo, itv_clk, ev_sel} = '0;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK(pin_oe_n, 8'hff)
        `CHK({pin_out, pullup_en}, 16'h0)
        `CHK({ei3, ei2, ei1, ev_in, cap_in}, 5'b11100)
        rd_chk(OFF_DIRECTION, 32'hff);
        rd_chk(OFF_PULLUP_CONTROL, 32'h0);
        rd_chk(OFF_PIN_FUNCTION_SELECT, 32'h0);
        wr(OFF_DIRECTION, 8'hff);
        rd_chk(OFF_OUTPUT_LATCH, 32'h0);
        apb(1'b1, OFF_OUTPUT_LATCH, 32'h5a, 4'h0);
        rd_chk(OFF_OUTPUT_LATCH, 32'h0);
        apb(1'b1, 16'hff00, 32'h5a, 4'hf);
        `CHK({err, rdv}, 33'h100000000)
        wr(OFF_OUTPUT_LATCH, 8'ha5);
        rd_chk(OFF_OUTPUT_LATCH, 32'ha5);
        $display("reset and register map test done");
        // Random directions, latch, pull-ups and board levels
        for (int i = 0; i < 24; i++) begin
            latch = 8'($random(seed));
            dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            pucr = 8'($random(seed));
            drv_val <= 8'($random(seed));
            drv_en <= ~dir;
            wr(OFF_OUTPUT_LATCH, latch);
            wr(OFF_DIRECTION, dir);
            wr(OFF_PULLUP_CONTROL, pucr);
            settle();
            rd_chk(OFF_OUTPUT_LATCH,
                   exp_port(latch, dir, drv_val));
            `CHK(pin_oe_n, ~dir)
            `CHK(pin_out & dir, latch & dir)
            `CHK(pullup_en, pucr & ~dir)
            rd_chk(OFF_PULLUP_CONTROL, {24'h0, pucr});
            rd_chk(OFF_DIRECTION, 32'hff);
            `CHK({ei3, ei2, ei1, ev_in, cap_in}, 5'b11100)
        end
        // Released input pins with pull-ups on read high
        drv_en <= 8'h00;
        wr(OFF_DIRECTION, 8'h00);
        wr(OFF_PULLUP_CONTROL, 8'hff);
        settle();
        rd_chk(OFF_OUTPUT_LATCH, 32'hff);
        $display("direction and pull-up test done");
        // Alternate functions, reserved bit written as one
        for (int i = 0; i < 16; i++) begin
            mode = (i == 0) ? 8'hff : 8'($random(seed)) | 8'h10;
            latch = 8'($random(seed));
            per = 3'($random(seed));
            lo = exp_low(mode, latch, per);
            drv_val <= 8'($random(seed));
            drv_en <= mode & MODE_ALT_IN_MASK;
            {cmp_hi, cmp_lo, itv_clk} <= per;
            ev_sel <= i[0] ? 3'h0 : 3'($random(seed));
            wr(OFF_DIRECTION, 8'hff);
            wr(OFF_OUTPUT_LATCH, latch);
            wr(OFF_PIN_FUNCTION_SELECT, mode);
            settle();
            rd_chk(OFF_PIN_FUNCTION_SELECT, 32'(mode & 8'hef));
            rd_chk(OFF_OUTPUT_LATCH, {24'h0, latch});
            `CHK(pin_oe_n, mode & MODE_ALT_IN_MASK)
            `CHK(pin_out & 8'h07, lo)
            `CHK({ei3, ei2, ei1}, ~mode[7:5] | drv_val[7:5])
            `CHK(cap_in, mode[3] & drv_val[3])
            `CHK(ev_in, mode[7] & (ev_sel == 3'h0) & drv_val[7])
            `CHK(pin_out[2:1], lo[2:1])
            `CHK(pin_out[0], mode[0] ? itv_clk : latch[0])
        end
        $display("pin function test done");
        end_sim();
    end
endmodule

`default_nettype wire
